/* File: rtl/deti_pkg.sv */
// constants, types and mapping helper of the dimm error threshold block
// assumes one clock domain and a plain strobe register port
package deti_pkg;

    localparam int CH_N   = 3;
    localparam int SLOT_N = 4;
    localparam int DIMM_N = CH_N * SLOT_N;
    localparam int CNT_W  = 15;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets
    localparam logic [ADDR_W-1:0] STATUS_OFF   = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL_OFF     = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'h0C;

    // field positions
    localparam int OVF_LSB    = 0;
    localparam int FAIL_LSB   = 12;
    localparam int FAIL_W     = 2;
    localparam int LIMIT_LSB  = 0;
    localparam int SMI_EN_BIT = 15;
    localparam int NMI_EN_BIT = 16;

    // interrupt cause bits
    localparam int EV_THRESH = 0;
    localparam int EV_SCRUB  = 1;
    localparam int EV_REDUND = 2;
    localparam int EV_N      = 3;

    // reset values
    localparam logic [DIMM_N-1:0] OVF_RST   = 12'h000;
    localparam logic [FAIL_W-1:0] FAIL_RST  = 2'h0;
    localparam logic [CNT_W-1:0]  LIMIT_RST = 15'h0000;
    localparam logic              EN_RST    = 1'b0;
    localparam logic [EV_N-1:0]   IRQ_RST   = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    typedef enum {DETI_SEL_NONE, DETI_SEL_SMI, DETI_SEL_NMI} deti_sel_t;

    // status bit of a counter slot; dense means three or more dimms
    function automatic int unsigned deti_bit(input int unsigned ch,
                                             input int unsigned slot,
                                             input logic dense);
        int unsigned dimm;
        int unsigned rank_hi;
        dimm    = dense ? slot : slot / 2;
        rank_hi = dense ? 0 : slot % 2;
        return dense ? ch * 4 + dimm : ch * 4 + dimm * 2 + rank_hi;
    endfunction

endpackage

/* File: rtl/deti_evt_if.sv */
// event bundle between comparator, interrupt selector and top
// assumes all parties on the same clock
`timescale 1ns/1ps
`default_nettype none
interface deti_evt_if;
    import deti_pkg::*;
    logic [DIMM_N-1:0] over;
    logic              meet_pulse;
    logic              event_pulse;
    logic              smi_en;
    logic              nmi_en;
    logic              smi_pulse;
    logic              nmi_pulse;

    modport cmp (output over, meet_pulse);
    modport sel (input event_pulse, smi_en, nmi_en,
                 output smi_pulse, nmi_pulse);
    modport top (input over, meet_pulse, smi_pulse, nmi_pulse,
                 output event_pulse, smi_en, nmi_en);
endinterface
`default_nettype wire

/* File: rtl/deti_limit_cmp.sv */
// compares every counter slot with the limit
// assumes counters synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module deti_limit_cmp
    import deti_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    input  wire logic [DIMM_N*CNT_W-1:0] count_in,
    input  wire logic [CNT_W-1:0]        limit_in,
    input  wire logic [CH_N-1:0]         dense_in,
    deti_evt_if.cmp                      evt
);
    import deti_pkg::*;

    logic [DIMM_N-1:0] meet;
    logic [DIMM_N-1:0] meet_r;

    always_comb begin
        evt.over = '0;
        for (int c = 0; c < CH_N; c++) begin
            for (int s = 0; s < SLOT_N; s++) begin
                if (count_in[(c*SLOT_N+s)*CNT_W +: CNT_W] > limit_in) begin
                    evt.over[deti_bit(c, s, dense_in[c])] = 1'b1;
                end
            end
        end
    end

    genvar k;
    generate
        for (k = 0; k < DIMM_N; k++) begin : g_meet
            assign meet[k] = count_in[k*CNT_W +: CNT_W] >= limit_in;
        end
    endgenerate

    // starts high so no event at reset release
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meet_r <= '1;
        end else begin
            meet_r <= meet;
        end
    end

    assign evt.meet_pulse = |(meet & ~meet_r);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_meet_reach: assert property (
        (count_in[2*CNT_W +: CNT_W] < limit_in) ##1
        (count_in[2*CNT_W +: CNT_W] >= limit_in && $stable(limit_in))
        |-> evt.meet_pulse)
        else $error("counter reaching limit gave no event");

    a_meet_once: assert property (
        evt.meet_pulse ##1 ($stable(count_in) && $stable(limit_in))
        |-> !evt.meet_pulse)
        else $error("event repeated while condition persists");
endmodule
`default_nettype wire

/* File: rtl/deti_irq_sel.sv */
// picks at most one interrupt kind per event and pulses it
// assumes event pulses one cycle wide
`timescale 1ns/1ps
`default_nettype none
module deti_irq_sel
    import deti_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic reset_in,
    deti_evt_if.sel   evt
);
    import deti_pkg::*;

    deti_sel_t sel;

    // mode independent: no mirror input on purpose
    always_comb begin
        if (!evt.event_pulse) begin
            sel = DETI_SEL_NONE;
        end else if (evt.smi_en) begin
            sel = DETI_SEL_SMI;
        end else if (evt.nmi_en) begin
            sel = DETI_SEL_NMI;
        end else begin
            sel = DETI_SEL_NONE;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            evt.smi_pulse <= 1'b0;
            evt.nmi_pulse <= 1'b0;
        end else begin
            unique case (sel)
                DETI_SEL_SMI: begin
                    evt.smi_pulse <= 1'b1;
                    evt.nmi_pulse <= 1'b0;
                end
                DETI_SEL_NMI: begin
                    evt.smi_pulse <= 1'b0;
                    evt.nmi_pulse <= 1'b1;
                end
                DETI_SEL_NONE: begin
                    evt.smi_pulse <= 1'b0;
                    evt.nmi_pulse <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_only_smi: assert property (
        evt.event_pulse && evt.smi_en && evt.nmi_en
        |=> evt.smi_pulse && !evt.nmi_pulse)
        else $error("nmi sent with both enables set");

    a_nmi_gate: assert property (
        evt.event_pulse && !evt.smi_en
        |=> evt.nmi_pulse == $past(evt.nmi_en))
        else $error("nmi does not follow its enable");
endmodule
`default_nettype wire

/* File: rtl/deti_top.sv */
// dimm error threshold status and interrupt selection
// assumes counters and flags synchronous, one-cycle register strobes
//
// How it works
// - a slot over the limit sets its overflow status bit
// - overflow bits stay set; writing zero clears, writing one keeps
// - failing dimm id captured on redundancy loss, cleared by zero
// - dense channels: status bit is channel times four plus dimm
// - sparse channels: bit is channel*4 + dimm*2 + high rank pair
// - control bit 16 enables non-maskable interrupt, resets to zero
// - control bit 15 enables system management interrupt, resets zero
// - with both enables set, only system management interrupt is sent
// - system management enable acts the same in every channel mode
// - a counter reaching the limit is an interrupt event
// - scrub or spare completion rising is an interrupt event
// - redundancy loss rising is an interrupt event
// - limit is a 15-bit field at bits 14..0, reset zero
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module deti_top
    import deti_pkg::*;
(
    input  wire logic                             clk_in,
    input  wire logic                             reset_in,
    input  wire logic [deti_pkg::ADDR_W-1:0]      reg_addr_in,
    input  wire logic [deti_pkg::DATA_W-1:0]      reg_wdata_in,
    input  wire logic                             reg_wr_in,
    input  wire logic                             reg_rd_in,
    output logic      [deti_pkg::DATA_W-1:0]      reg_rdata_out,
    input  wire logic [deti_pkg::DIMM_N*deti_pkg::CNT_W-1:0]
                                                  corrected_error_counter_in,
    input  wire logic [deti_pkg::CH_N-1:0]        dense_pop_in,
    input  wire logic                             scrub_spare_done_flag_in,
    input  wire logic                             redundancy_lost_flag_in,
    input  wire logic [deti_pkg::FAIL_W-1:0]      failing_dimm_in,
    output logic
        system_management_interrupt_out,
    output logic                                  nmi_out,
    output logic                                  irq_out
);
    import deti_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] off);
        return addr == off;
    endfunction

    logic [DIMM_N-1:0] ovf_status_r;
    logic [FAIL_W-1:0] fail_dimm_r;
    logic              smi_en_r;
    logic              nmi_en_r;
    logic [CNT_W-1:0]  limit_r;
    logic [EV_N-1:0]   irq_stat_r;
    logic [EV_N-1:0]   irq_mask_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              scrub_q_r;
    logic              redund_q_r;
    logic              scrub_rise;
    logic              redund_rise;
    logic              status_wr;
    logic              ctrl_wr;
    logic              irq_stat_wr;
    logic              irq_mask_wr;
    logic [EV_N-1:0]   ev_set;

    deti_evt_if evt ();

    deti_limit_cmp u_cmp (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .count_in (corrected_error_counter_in),
        .limit_in (limit_r),
        .dense_in (dense_pop_in),
        .evt      (evt.cmp)
    );

    deti_irq_sel u_sel (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .evt      (evt.sel)
    );

    assign status_wr   = reg_wr_in && hit(reg_addr_in, STATUS_OFF);
    assign ctrl_wr     = reg_wr_in && hit(reg_addr_in, CTRL_OFF);
    assign irq_stat_wr = reg_wr_in && hit(reg_addr_in, IRQ_STAT_OFF);
    assign irq_mask_wr = reg_wr_in && hit(reg_addr_in, IRQ_MASK_OFF);

    // rising edges of the flags from neighbouring units
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            scrub_q_r  <= 1'b0;
            redund_q_r <= 1'b0;
        end else begin
            scrub_q_r  <= scrub_spare_done_flag_in;
            redund_q_r <= redundancy_lost_flag_in;
        end
    end

    assign scrub_rise  = scrub_spare_done_flag_in && !scrub_q_r;
    assign redund_rise = redundancy_lost_flag_in && !redund_q_r;

    assign ev_set[EV_THRESH] = evt.meet_pulse;
    assign ev_set[EV_SCRUB]  = scrub_rise;
    assign ev_set[EV_REDUND] = redund_rise;

    assign evt.event_pulse = |ev_set;
    assign evt.smi_en      = smi_en_r;
    assign evt.nmi_en      = nmi_en_r;

    assign system_management_interrupt_out = evt.smi_pulse;
    assign nmi_out                         = evt.nmi_pulse;

    // overflow bits: zero clears, set wins over clear
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ovf_status_r <= OVF_RST;
        end else if (status_wr) begin
            ovf_status_r <= (ovf_status_r
                             & reg_wdata_in[OVF_LSB +: DIMM_N])
                            | evt.over;
        end else begin
            ovf_status_r <= ovf_status_r | evt.over;
        end
    end

    // failing dimm id, capture wins over a clearing write
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            fail_dimm_r <= FAIL_RST;
        end else if (redund_rise) begin
            fail_dimm_r <= failing_dimm_in;
        end else if (status_wr) begin
            fail_dimm_r <= fail_dimm_r
                           & reg_wdata_in[FAIL_LSB +: FAIL_W];
        end
    end

    // control: enables and limit
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            smi_en_r <= EN_RST;
            nmi_en_r <= EN_RST;
            limit_r  <= LIMIT_RST;
        end else if (ctrl_wr) begin
            smi_en_r <= reg_wdata_in[SMI_EN_BIT];
            nmi_en_r <= reg_wdata_in[NMI_EN_BIT];
            limit_r  <= reg_wdata_in[LIMIT_LSB +: CNT_W];
        end
    end

    // sticky causes, write one clears, set wins
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_stat_r <= IRQ_RST;
        end else if (irq_stat_wr) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata_in[EV_N-1:0]) | ev_set;
        end else begin
            irq_stat_r <= irq_stat_r | ev_set;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_mask_r <= IRQ_RST;
        end else if (irq_mask_wr) begin
            irq_mask_r <= reg_wdata_in[EV_N-1:0];
        end
    end

    assign irq_out = |(irq_stat_r & irq_mask_r);

    // read mux, unmapped reads return zero
    always_comb begin
        rdata_nxt = RDATA_RST;
        if (reg_rd_in) begin
            if (hit(reg_addr_in, STATUS_OFF)) begin
                rdata_nxt[OVF_LSB +: DIMM_N]  = ovf_status_r;
                rdata_nxt[FAIL_LSB +: FAIL_W] = fail_dimm_r;
            end else if (hit(reg_addr_in, CTRL_OFF)) begin
                rdata_nxt[NMI_EN_BIT]          = nmi_en_r;
                rdata_nxt[SMI_EN_BIT]          = smi_en_r;
                rdata_nxt[LIMIT_LSB +: CNT_W]  = limit_r;
            end else if (hit(reg_addr_in, IRQ_STAT_OFF)) begin
                rdata_nxt[EV_N-1:0] = irq_stat_r;
            end else if (hit(reg_addr_in, IRQ_MASK_OFF)) begin
                rdata_nxt[EV_N-1:0] = irq_mask_r;
            end
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= RDATA_RST;
        end else begin
            reg_rdata_out <= rdata_nxt;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_ovf_set_bit: assert property (
        evt.over != 12'h000
        |=> (ovf_status_r & $past(evt.over)) == $past(evt.over))
        else $error("overflow did not set status");

    a_ovf_sticky: assert property (
        !status_wr |=> ($past(ovf_status_r) & ~ovf_status_r) == 12'h000)
        else $error("overflow bit lost without a write");

    a_ovf_zero_clear: assert property (
        status_wr && evt.over == 12'h000
        |=> ovf_status_r == $past(ovf_status_r & reg_wdata_in[11:0]))
        else $error("write zero clear misbehaves");

    a_fail_capture: assert property (
        redund_rise |=> fail_dimm_r == $past(failing_dimm_in))
        else $error("failing dimm id not captured");

    a_map_dense_bit: assert property (
        dense_pop_in[0]
        && corrected_error_counter_in[2*CNT_W +: CNT_W] > limit_r
        |-> evt.over[2])
        else $error("dense mapping wrong");

    a_map_sparse_bit: assert property (
        !dense_pop_in[1]
        && corrected_error_counter_in[7*CNT_W +: CNT_W] > limit_r
        |-> evt.over[7])
        else $error("sparse mapping wrong");

    a_smi_event: assert property (
        evt.event_pulse && smi_en_r
        |=> system_management_interrupt_out && !nmi_out)
        else $error("smi missing for event");

    a_no_event_quiet: assert property (
        !evt.event_pulse
        |=> !system_management_interrupt_out && !nmi_out)
        else $error("interrupt without an event");

    a_scrub_event: assert property (
        scrub_spare_done_flag_in && !scrub_q_r && smi_en_r
        |=> system_management_interrupt_out)
        else $error("scrub completion gave no interrupt");

    a_redund_event: assert property (
        redundancy_lost_flag_in && !redund_q_r && !smi_en_r && nmi_en_r
        |=> nmi_out)
        else $error("redundancy loss gave no nmi");

    a_ctrl_write: assert property (
        ctrl_wr |=> limit_r == $past(reg_wdata_in[14:0])
                    && smi_en_r == $past(reg_wdata_in[15])
                    && nmi_en_r == $past(reg_wdata_in[16]))
        else $error("control fields not stored");

    a_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside read cycle");

    a_ovf_new_bits: assert property (
        (ovf_status_r & ~$past(ovf_status_r) & ~$past(evt.over))
        == 12'h000)
        else $error("overflow bit set without an overflow");

    a_fail_clear: assert property (
        status_wr && !redund_rise
        |=> fail_dimm_r == $past(fail_dimm_r & reg_wdata_in[13:12]))
        else $error("failing dimm id not cleared by zero");

    a_fail_hold: assert property (
        !status_wr && !redund_rise |=> $stable(fail_dimm_r))
        else $error("failing dimm id changed on its own");

    a_ctrl_hold: assert property (
        !ctrl_wr
        |=> $stable(limit_r) && $stable(smi_en_r) && $stable(nmi_en_r))
        else $error("control fields changed without a write");

    a_rdata_status: assert property (
        reg_rd_in && hit(reg_addr_in, STATUS_OFF)
        |=> reg_rdata_out == {18'h0_0000, $past(fail_dimm_r),
                              $past(ovf_status_r)})
        else $error("status read data wrong");

    a_rdata_ctrl: assert property (
        reg_rd_in && hit(reg_addr_in, CTRL_OFF)
        |=> reg_rdata_out == {15'h0000, $past(nmi_en_r),
                              $past(smi_en_r), $past(limit_r)})
        else $error("control read data wrong");

    a_rdata_cause: assert property (
        reg_rd_in && hit(reg_addr_in, IRQ_STAT_OFF)
        |=> reg_rdata_out == {29'h0000_0000, $past(irq_stat_r)})
        else $error("cause read data wrong");

    a_smi_cause: assert property (
        system_management_interrupt_out
        |-> $past(evt.event_pulse) && $past(smi_en_r))
        else $error("smi without an enabled event");

    a_nmi_cause: assert property (
        nmi_out
        |-> $past(evt.event_pulse) && $past(nmi_en_r) && !$past(smi_en_r))
        else $error("nmi without an nmi-only event");

    a_irq_disabled: assert property (
        evt.event_pulse && !smi_en_r && !nmi_en_r
        |=> !system_management_interrupt_out && !nmi_out)
        else $error("interrupt sent with both enables off");

    a_cause_set: assert property (
        ev_set != 3'h0
        |=> (irq_stat_r & $past(ev_set)) == $past(ev_set))
        else $error("event did not set its cause bit");

    a_cause_sticky: assert property (
        !irq_stat_wr |=> ($past(irq_stat_r) & ~irq_stat_r) == 3'h0)
        else $error("cause bit lost without a write");

    a_cause_clear: assert property (
        irq_stat_wr && ev_set == 3'h0
        |=> irq_stat_r == $past(irq_stat_r & ~reg_wdata_in[2:0]))
        else $error("write one clear of cause misbehaves");

    a_mask_write: assert property (
        irq_mask_wr |=> irq_mask_r == $past(reg_wdata_in[2:0]))
        else $error("mask not stored");

    a_irq_high: assert property (
        (irq_stat_r & irq_mask_r) != 3'h0 |-> irq_out)
        else $error("unmasked cause without interrupt");

    a_irq_low: assert property (
        (irq_stat_r & irq_mask_r) == 3'h0 |-> !irq_out)
        else $error("interrupt without unmasked cause");

    c_smi_sent: cover property (system_management_interrupt_out);
    c_nmi_sent: cover property (nmi_out);
    c_irq_level: cover property (irq_out);
    c_fail_seen: cover property (redund_rise ##1 fail_dimm_r != 2'h0);
    c_both_en: cover property (evt.event_pulse && smi_en_r && nmi_en_r);
endmodule
`default_nettype wire

/* File: tb/deti_core_model.sv */
// core side model: counts interrupt pulses it receives
// assumes pulses one cycle wide, synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module deti_core_model (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       smi_in,
    input  wire logic       nmi_in,
    output logic      [7:0] smi_cnt_out,
    output logic      [7:0] nmi_cnt_out
);
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            smi_cnt_out <= 8'h00;
        end else if (smi_in === 1'b1) begin
            smi_cnt_out <= smi_cnt_out + 8'h01;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            nmi_cnt_out <= 8'h00;
        end else if (nmi_in === 1'b1) begin
            nmi_cnt_out <= nmi_cnt_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: tb/deti_top_test.sv */
// testbench of the dimm error threshold block
// assumes core model counts pulses; firmware role played by tasks
`timescale 1ns/1ps
`default_nettype none
module deti_top_test;
    import deti_pkg::*;
    logic                    clk_in = 1'b0;
    logic                    reset_in = 1'b1;
    logic [ADDR_W-1:0]       addr = 8'h00;
    logic [DATA_W-1:0]       wdata = 32'h0000_0000;
    logic                    wr = 1'b0;
    logic                    rd = 1'b0;
    logic [DATA_W-1:0]       rdata;
    logic [DIMM_N*CNT_W-1:0] cnt = '0;
    logic [CH_N-1:0]         dense = 3'b101;
    logic                    scrub = 1'b0;
    logic                    redund = 1'b0;
    logic [FAIL_W-1:0]       fail_id = 2'h0;
    logic                    system_management_interrupt;
    logic                    nmi;
    logic                    irq;
    logic [7:0]              smi_cnt;
    logic [7:0]              nmi_cnt;
    logic [7:0]              smi_last = 8'h00;
    logic [7:0]              nmi_last = 8'h00;
    int                      n_errors = 0;
    int                      n_checks = 0;
    int                      cycles = 0;

    always #2.5 clk_in = ~clk_in;

    deti_top deti_top_i (
        .clk_in                          (clk_in),
        .reset_in                        (reset_in),
        .reg_addr_in                     (addr),
        .reg_wdata_in                    (wdata),
        .reg_wr_in                       (wr),
        .reg_rd_in                       (rd),
        .reg_rdata_out                   (rdata),
        .corrected_error_counter_in      (cnt),
        .dense_pop_in                    (dense),
        .scrub_spare_done_flag_in        (scrub),
        .redundancy_lost_flag_in         (redund),
        .failing_dimm_in                 (fail_id),
        .system_management_interrupt_out (system_management_interrupt),
        .nmi_out                         (nmi),
        .irq_out                         (irq)
    );

    deti_core_model deti_core_model_i (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .smi_in      (system_management_interrupt),
        .nmi_in      (nmi),
        .smi_cnt_out (smi_cnt),
        .nmi_cnt_out (nmi_cnt)
    );

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1;
        chk("read data", rdata, exp);
    endtask

    task automatic slot(input int k, input logic [14:0] v);
        @(posedge clk_in);
        cnt[k*CNT_W +: CNT_W] <= v;
        repeat (3) @(posedge clk_in);
    endtask

    // pulses seen by the core since the last call
    task automatic pulses(input logic [7:0] e_smi, input logic [7:0] e_nmi);
        repeat (3) @(posedge clk_in);
        #1;
        chk("smi pulses", 32'(smi_cnt - smi_last), 32'(e_smi));
        chk("nmi pulses", 32'(nmi_cnt - nmi_last), 32'(e_nmi));
        smi_last = smi_cnt;
        nmi_last = nmi_cnt;
    endtask

    task automatic flag_rise(input bit which, input logic v);
        @(posedge clk_in);
        if (which) begin
            redund <= v;
        end else begin
            scrub <= v;
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'(i * 4), 32'h0000_0000);
        end
        wr_reg(CTRL_OFF, 32'h0000_8005);
        rd_chk(CTRL_OFF, 32'h0000_8005);
        wr_reg(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0000_0000);
        wr_reg(IRQ_MASK_OFF, 32'h0000_0007);
        // slot 2 reaches limit 5: event but no overflow yet
        slot(2, 15'h0005);
        pulses(8'h01, 8'h00);
        rd_chk(STATUS_OFF, 32'h0000_0000);
        chk("irq out", 32'(irq), 32'h0000_0001);
        rd_chk(IRQ_STAT_OFF, 32'h0000_0001);
        slot(2, 15'h0006);
        pulses(8'h00, 8'h00);
        rd_chk(STATUS_OFF, 32'h0000_0004);
        // sparse channel 1, dimm 1 high ranks
        slot(7, 15'h0009);
        pulses(8'h01, 8'h00);
        rd_chk(STATUS_OFF, 32'h0000_0084);
        slot(2, 15'h0000);
        slot(7, 15'h0000);
        rd_chk(STATUS_OFF, 32'h0000_0084);
        wr_reg(STATUS_OFF, 32'h0000_0FFF);
        rd_chk(STATUS_OFF, 32'h0000_0084);
        wr_reg(STATUS_OFF, 32'h0000_0004);
        rd_chk(STATUS_OFF, 32'h0000_0004);
        wr_reg(IRQ_STAT_OFF, 32'h0000_0001);
        rd_chk(IRQ_STAT_OFF, 32'h0000_0000);
        chk("irq out", 32'(irq), 32'h0000_0000);
        // both enables: only system management pulse
        wr_reg(CTRL_OFF, 32'h0001_8005);
        rd_chk(CTRL_OFF, 32'h0001_8005);
        flag_rise(1'b0, 1'b1);
        pulses(8'h01, 8'h00);
        repeat (4) @(posedge clk_in);
        pulses(8'h00, 8'h00);
        flag_rise(1'b0, 1'b0);
        // non-maskable only, redundancy loss of dimm 3
        wr_reg(CTRL_OFF, 32'h0001_0005);
        @(posedge clk_in);
        fail_id <= 2'h3;
        flag_rise(1'b1, 1'b1);
        pulses(8'h00, 8'h01);
        rd_chk(STATUS_OFF, 32'h0000_3004);
        rd_chk(IRQ_STAT_OFF, 32'h0000_0006);
        chk("irq out", 32'(irq), 32'h0000_0001);
        wr_reg(IRQ_MASK_OFF, 32'h0000_0000);
        #1;
        chk("irq out", 32'(irq), 32'h0000_0000);
        flag_rise(1'b1, 1'b0);
        wr_reg(STATUS_OFF, 32'h0000_0000);
        rd_chk(STATUS_OFF, 32'h0000_0000);
        // both enables off: events still counted, no pulse
        wr_reg(CTRL_OFF, 32'h0000_0005);
        wr_reg(IRQ_STAT_OFF, 32'h0000_0007);
        flag_rise(1'b0, 1'b1);
        pulses(8'h00, 8'h00);
        rd_chk(IRQ_STAT_OFF, 32'h0000_0002);
        final_report();
    end
endmodule
`default_nettype wire
